// ### bench/undervoltage_and_fuse_config_sva.sv
// supervisor and fuse checker, bound to the top ports
// assumes one clock, active-low reset
`timescale 1ns/1ps
`default_nettype none
// ==========
// properties
module uv_fuse_chk (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic batteryBelowLatchLevel,
   input wire logic batteryAboveRecoveryLevel,
   input wire logic pumpFaultFlag,
   input wire logic readStateCmd,
   input wire logic readAllStateCmd,
   input wire logic twoTargetMoveCmd,
   input wire logic fuseProgramCmd,
   input wire logic [15:0] currentPosition,
   input wire uv_fuse_pkg::uv_state_e uvState,
   input wire logic motionHalted,
   input wire logic coilsHighZ,
   input wire logic resumeMotion,
   input wire logic undervoltageLatchFlag,
   input wire logic lostStepsFlag,
   input wire logic [15:0] targetPosition,
   input wire logic twoTargetAccepted,
   input wire logic twoTargetRefused,
   input wire logic fuseProgramDone,
   input wire logic fuseProgramRejected
);
   logic statusRead;
   assign statusRead = readStateCmd | readAllStateCmd;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   a_fault_halts: assert property (
      uvState == uv_fuse_pkg::UV_NORMAL && (batteryBelowLatchLevel || pumpFaultFlag)
      |=> uvState == uv_fuse_pkg::UV_HARD && motionHalted && coilsHighZ
      && undervoltageLatchFlag && lostStepsFlag) else $error("fault did not halt");
   a_hard_to_halt: assert property (
      uvState == uv_fuse_pkg::UV_HARD |=> uvState == uv_fuse_pkg::UV_HALT && coilsHighZ)
      else $error("hard state not followed by halt");
   a_target_kept: assert property (
      uvState == uv_fuse_pkg::UV_HALT |-> $stable(targetPosition))
      else $error("target moved while halted");
   a_resume_on_recovery: assert property (
      uvState == uv_fuse_pkg::UV_HALT && batteryAboveRecoveryLevel && !pumpFaultFlag
      |=> uvState == uv_fuse_pkg::UV_NORMAL && resumeMotion) else $error("no resume");
   a_shutdown_copy: assert property (
      uvState == uv_fuse_pkg::UV_HALT ##1 uvState == uv_fuse_pkg::UV_SHUTDOWN
      |-> targetPosition == $past(currentPosition)) else $error("target not copied");
   a_shutdown_holds: assert property (
      uvState == uv_fuse_pkg::UV_SHUTDOWN && !statusRead
      |=> uvState == uv_fuse_pkg::UV_SHUTDOWN) else $error("shutdown left without read");
   a_flags_sticky: assert property (
      undervoltageLatchFlag && !(statusRead && batteryAboveRecoveryLevel)
      |=> undervoltageLatchFlag && lostStepsFlag) else $error("flags cleared early");
   a_dual_refused: assert property (
      twoTargetMoveCmd && (undervoltageLatchFlag || lostStepsFlag || pumpFaultFlag)
      |=> twoTargetRefused && !twoTargetAccepted) else $error("two-target move taken");
   a_zap_answer: assert property (
      fuseProgramCmd |=> fuseProgramDone != fuseProgramRejected) else $error("zap unanswered");
endmodule
bind undervoltage_and_fuse_config uv_fuse_chk uv_fuse_chk_i (.core_clk(core_clk),
   .rstn(rstn), .batteryBelowLatchLevel(batteryBelowLatchLevel),
   .batteryAboveRecoveryLevel(batteryAboveRecoveryLevel), .pumpFaultFlag(pumpFaultFlag),
   .readStateCmd(readStateCmd), .readAllStateCmd(readAllStateCmd),
   .twoTargetMoveCmd(twoTargetMoveCmd), .fuseProgramCmd(fuseProgramCmd),
   .currentPosition(currentPosition), .uvState(uvState), .motionHalted(motionHalted),
   .coilsHighZ(coilsHighZ), .resumeMotion(resumeMotion),
   .undervoltageLatchFlag(undervoltageLatchFlag), .lostStepsFlag(lostStepsFlag),
   .targetPosition(targetPosition), .twoTargetAccepted(twoTargetAccepted),
   .twoTargetRefused(twoTargetRefused), .fuseProgramDone(fuseProgramDone),
   .fuseProgramRejected(fuseProgramRejected));
`default_nettype wire

// ### bench/undervoltage_and_fuse_config_test.sv
// self-checking bench: supervisor, fuse store and parameter decode
// assumes package, partner and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) \
   testsRun++; \
   if ((s) !== (e)) \
   begin \
      failures++; \
      $display("[FAIL] %s expected %h seen %h", n, e, s); \
   end
// ==========
// bench
module undervoltage_and_fuse_config_test;
   localparam logic [6:0] RD = 7'h01, RDA = 7'h02, SET = 7'h04, TWO = 7'h08, LD = 7'h40;
   int testsRun = 0, failures = 0;
   logic core_clk = 1'b0, rstn = 1'b0, below = 1'b0, recov = 1'b1, pump = 1'b0;
   logic stopped = 1'b1, contMode = 1'b0, lost = 1'b0, ovf = 1'b0, lockF = 1'b0, lockU = 1'b0;
   logic [2:0] pins = 3'h0;
   logic [15:0] curPos = 16'h0000;
   logic [31:0] rnd = 32'h26E45B1E;
   logic [7:0] fz [8];
   logic [7:0] e8;
   logic [1:0] e2;
   logic [7:0] expRd [$];
   logic [1:0] expZap [$], expTwo [$];
   logic rd, rda, setT, two, prg, rb, ld, flagUv, flagLost, coilsZ, acc, rej2, rdV, done, rej;
   logic absEn, relEn, goSafe, pwmOff, gnd, cw, sh;
   logic [15:0] tgtIn, tgt;
   logic [2:0] fa;
   logic [7:0] fd, rdData;
   logic [6:0] node;
   logic [10:0] safeRam;
   logic [9:0] abs, rel, ma;
   logic [4:0] micro;
   uv_fuse_pkg::motion_settings_s msIn, act, ms;
   uv_fuse_pkg::uv_state_e st;
   uv_bus_master uv_bus_master_i (.core_clk(core_clk), .readStateCmd(rd),
      .readAllStateCmd(rda), .setTargetCmd(setT), .twoTargetMoveCmd(two),
      .fuseProgramCmd(prg), .fuseReadbackCmd(rb), .loadMotionSettingsCmd(ld),
      .newTarget(tgtIn), .fuseAddr(fa), .fuseWriteData(fd), .motionSettingsIn(msIn));
   undervoltage_and_fuse_config #(.UV_WINDOW_CYCLES(50), .HOLD_REDUCE_CYCLES(5),
      .FACTORY_TRIM0(8'h5A)) undervoltage_and_fuse_config_i (.core_clk(core_clk),
      .rstn(rstn), .batteryBelowLatchLevel(below), .batteryAboveRecoveryLevel(recov),
      .pumpFaultFlag(pump), .readStateCmd(rd), .readAllStateCmd(rda), .setTargetCmd(setT),
      .newTarget(tgtIn), .twoTargetMoveCmd(two), .currentPosition(curPos),
      .motorStopped(stopped), .continuousSpeedMode(contMode), .linkLost(lost),
      .errorCounterOverflow(ovf), .addressPinBits(pins), .loadMotionSettingsCmd(ld),
      .motionSettingsIn(msIn), .fuseProgramCmd(prg), .fuseReadbackCmd(rb), .fuseAddr(fa),
      .fuseWriteData(fd), .uvState(st), .motionHalted(), .coilsHighZ(coilsZ),
      .resumeMotion(), .undervoltageLatchFlag(flagUv), .lostStepsFlag(flagLost),
      .targetPosition(tgt), .twoTargetAccepted(acc), .twoTargetRefused(rej2),
      .fuseReadData(rdData), .fuseReadValid(rdV), .fuseProgramDone(done),
      .fuseProgramRejected(rej), .nodeAddress(node), .activeSettings(act),
      .safePositionRam(safeRam), .gotoSafePlace(goSafe), .absThresholdEnable(absEn),
      .absThreshold10mV(abs), .relThresholdEnable(relEn), .relThreshold10mV(rel),
      .coilCurrentMa(ma), .pwmOff(pwmOff), .bottomGrounded(gnd), .microstepsPerFullStep(micro),
      .rotateClockwise(cw));
   initial forever #5 core_clk = ~core_clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic conclude;
      $display("checks %0d failures %0d", testsRun, failures);
      if (failures == 0 && testsRun > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic powerUp;
      rstn = 1'b0;
      repeat (16) @(negedge core_clk);
      rstn = 1'b1;
      repeat (5) @(negedge core_clk);
   endtask
   task automatic zapChk(input logic [2:0] a, input logic [7:0] d);
      logic ok;
      ok = !lockU && !(lockF && a <= 3'h1);
      expZap.push_back(ok ? 2'b10 : 2'b01);
      if (ok)
         fz[a] = fz[a] | d;
      expRd.push_back(fz[a]);
      {lockF, lockU} = fz[7][1:0];
      uv_bus_master_i.zap(a, d);
   endtask
   task automatic c(input logic [6:0] k, input logic [15:0] d);
      uv_bus_master_i.cmd(k, 3'h0, d, '0);
   endtask
   task automatic dual(input logic ok);
      expTwo.push_back(ok ? 2'b10 : 2'b01);
      c(TWO, 16'h0000);
   endtask
   // oldest note first
   always @(negedge core_clk)
   begin
      if (rdV)
      begin
         e8 = expRd.pop_front();
         `CHK("readback", e8, rdData)
      end
      if (done | rej)
      begin
         e2 = expZap.pop_front();
         `CHK("zap answer", e2, {done, rej})
      end
      if (acc | rej2)
      begin
         e2 = expTwo.pop_front();
         `CHK("two-target", e2, {acc, rej2})
      end
   end
   initial
   begin
      repeat (20000) @(posedge core_clk);
      failures++;
      conclude();
   end
   initial
   begin
      foreach (fz[i]) fz[i] = 8'h00;
      fz[0] = 8'h5A;
      pins = rnd[2:0];
      powerUp();
      rnd = lfsr(rnd);
      c(SET, rnd[15:0]);
      `CHK("target", rnd[15:0], tgt)
      below = 1'b1;
      recov = 1'b0;
      repeat (3) @(negedge core_clk);
      `CHK("halted", {uv_fuse_pkg::UV_HALT, 3'b111}, {st, flagUv, flagLost, coilsZ})
      c(SET, ~rnd[15:0]);
      `CHK("target kept", rnd[15:0], tgt)
      dual(1'b0);
      below = 1'b0;
      recov = 1'b1;
      repeat (3) @(negedge core_clk);
      `CHK("resumed", {uv_fuse_pkg::UV_NORMAL, 2'b11}, {st, flagUv, flagLost})
      c(SET, ~rnd[15:0]);
      `CHK("target taken", ~rnd[15:0], tgt)
      dual(1'b0);
      c(RD, 16'h0000);
      `CHK("flags cleared", 2'b00, {flagUv, flagLost})
      dual(1'b1);
      curPos = rnd[31:16];
      pump = 1'b1;
      repeat (60) @(negedge core_clk);
      `CHK("shutdown", {uv_fuse_pkg::UV_SHUTDOWN, rnd[31:16]}, {st, tgt})
      c(RDA, 16'h0000);
      pump = 1'b0;
      repeat (2) @(negedge core_clk);
      `CHK("still down", uv_fuse_pkg::UV_SHUTDOWN, st)
      c(RDA, 16'h0000);
      `CHK("restarted", uv_fuse_pkg::UV_NORMAL, st)
      rnd = lfsr(rnd);
      zapChk(3'h2, rnd[7:0]);
      zapChk(3'h3, rnd[15:8]);
      zapChk(3'h3, rnd[23:16]);
      zapChk(3'h4, rnd[31:24]);
      zapChk(3'h7, {rnd[5:0], 2'b10});
      zapChk(3'h0, 8'hA5);
      zapChk(3'h7, 8'h01);
      zapChk(3'h4, 8'hFF);
      `CHK("node before cycle", {4'h0, pins}, node)
      powerUp();
      `CHK("node", {fz[2][3:0], pins}, node)
      `CHK("loaded", {fz[2][7:4], fz[3], fz[4]}, act[41:22])
      `CHK("loaded rel", fz[7][7:2], {act.relativeMotionThreshold, act.microstepResolution})
      for (int k = 0; k < 4; k++)
      begin
         rnd = lfsr(rnd);
         ms = {rnd, rnd[9:0]};
         ms.microstepResolution = uv_fuse_pkg::microstep_resolution_e'(k[1:0]);
         ms.absoluteMotionThreshold = 4'(k * 5);
         ms.relativeMotionThreshold = 4'(15 - k * 5);
         ms.holdCode = 4'hF;
         ms.safePosition = k[0] ? uv_fuse_pkg::SAFE_KEEP_CODE : {1'b0, rnd[7:0]};
         {lost, ovf, stopped, contMode} = {k[1], !k[1], 1'b0, k[0]};
         uv_bus_master_i.cmd(LD, 3'h0, 16'h0000, ms);
         repeat (3) @(negedge core_clk);
         `CHK("abs", {k != 0, 10'(k * 250)}, {absEn, abs})
         `CHK("rel", {k != 3, 10'((15 - k * 5) * 25)}, {relEn, rel})
         `CHK("microsteps", 5'(2 << k), micro)
         `CHK("safe ram", {ms.safePosition, 2'b00}, safeRam)
         `CHK("safe go", !k[0], goSafe)
         `CHK("run current", uv_fuse_pkg::CURRENT_MA[ms.runCode], ma)
         `CHK("node kept", {fz[2][3:0], pins}, node)
         if (!k[0])
            sh = ms.shaft;
         `CHK("direction", sh, cw)
         stopped = 1'b1;
         repeat (3) @(negedge core_clk);
         `CHK("hold low", uv_fuse_pkg::CURRENT_MA[0], ma)
         repeat (9) @(negedge core_clk);
         `CHK("hold off", {uv_fuse_pkg::ZERO_MA, 2'b11}, {ma, pwmOff, gnd})
      end
      `CHK("queues", 0, expRd.size() + expZap.size() + expTwo.size())
      conclude();
   end
endmodule
`default_nettype wire

// ### bench/uv_bus_master.sv
// bus master partner: issues status, target, move, settings and fuse commands as strobes
// assumes the bench calls its tasks from a single process
`timescale 1ns/1ps
`default_nettype none
// ==========
// command strobes
module uv_bus_master (
   input wire logic core_clk,
   output logic readStateCmd,
   output logic readAllStateCmd,
   output logic setTargetCmd,
   output logic twoTargetMoveCmd,
   output logic fuseProgramCmd,
   output logic fuseReadbackCmd,
   output logic loadMotionSettingsCmd,
   output logic [15:0] newTarget,
   output logic [2:0] fuseAddr,
   output logic [7:0] fuseWriteData,
   output uv_fuse_pkg::motion_settings_s motionSettingsIn
);
   logic [6:0] strobes = 7'h00;
   assign {loadMotionSettingsCmd, fuseReadbackCmd, fuseProgramCmd, twoTargetMoveCmd} = strobes[6:3];
   assign {setTargetCmd, readAllStateCmd, readStateCmd} = strobes[2:0];
   initial {newTarget, fuseAddr, fuseWriteData, motionSettingsIn} = '0;
   // one strobe per call
   task automatic cmd(input logic [6:0] k, input logic [2:0] a, input logic [15:0] d,
      input uv_fuse_pkg::motion_settings_s s);
      @(negedge core_clk);
      strobes = k;
      fuseAddr = a;
      fuseWriteData = d[7:0];
      newTarget = d;
      motionSettingsIn = s;
      @(negedge core_clk);
      strobes = 7'h00;
      // garbage after release
      fuseWriteData = ~fuseWriteData;
      newTarget = ~newTarget;
   endtask
   // every zap is read back at once
   task automatic zap(input logic [2:0] a, input logic [7:0] d);
      cmd(7'h10, a, {8'h00, d}, '0);
      cmd(7'h20, a, 16'h0000, '0);
   endtask
endmodule
`default_nettype wire

// ### inc/uv_fuse_pkg.sv
// constants, field layout and carrier types
// assumes a single 100 MHz core clock
package uv_fuse_pkg;
   localparam int CLK_MHZ = 100;
   localparam int UV_WINDOW_S = 15;
   localparam longint UV_WINDOW_CYCLES = longint'(UV_WINDOW_S) * CLK_MHZ * 1000000;
   localparam int HOLD_REDUCE_US = 10;
   localparam int HOLD_REDUCE_CYCLES = HOLD_REDUCE_US * CLK_MHZ;
   // fuse byte addresses
   localparam logic [2:0] ADDR_OSC_CURRENT_REFERENCE_TRIM = 3'h0;
   localparam logic [2:0] ADDR_BUS_TRIM = 3'h1;
   localparam logic [2:0] ADDR_THR_NODE = 3'h2;
   localparam logic [2:0] ADDR_CURRENT = 3'h3;
   localparam logic [2:0] ADDR_SPEED = 3'h4;
   localparam logic [2:0] ADDR_SAFE_HI = 3'h5;
   localparam logic [2:0] ADDR_SAFE_LO = 3'h6;
   localparam logic [2:0] ADDR_REL_LOCK = 3'h7;
   localparam logic [2:0] FACTORY_LAST_ADDR = 3'h1;
   // field positions (lsb) within their byte
   localparam int HI_NIB = 4;
   localparam int LO_NIB = 0;
   localparam int SAFE_HI_LSB = 5;
   localparam int SHAFT_BIT = 4;
   localparam int SAFE_LO_LSB = 2;
   localparam int LINKSAFE_BIT = 1;
   localparam int SLEEP_BIT = 0;
   localparam int STEP_LSB = 2;
   localparam int FACTORY_LOCK_BIT = 1;
   localparam int USER_LOCK_BIT = 0;
   localparam logic [7:0] FUSE_BLANK = 8'h00;
   // safe position keep pattern
   localparam logic [8:0] SAFE_KEEP_CODE = 9'h100;
   localparam logic [3:0] HOLD_OFF_CODE = 4'hF;
   localparam logic [9:0] ABS_STEP_10MV = 10'h032;
   localparam logic [9:0] REL_STEP_10MV = 10'h019;
   // coil amplitude in mA per code
   localparam logic [9:0] CURRENT_MA [16] = '{
      10'h03B, 10'h047, 10'h054, 10'h064, 10'h077, 10'h08D, 10'h0A8, 10'h0C8,
      10'h0EE, 10'h11B, 10'h150, 10'h190, 10'h1DC, 10'h236, 10'h2A1, 10'h320};
   localparam logic [9:0] ZERO_MA = 10'h000;

   typedef enum logic [1:0] {
      UV_NORMAL = 2'b00,
      UV_HARD = 2'b01,
      UV_HALT = 2'b11,
      UV_SHUTDOWN = 2'b10
   } uv_state_e;

   typedef enum logic [1:0] {
      STEP_HALF = 2'b00,
      STEP_QUARTER = 2'b01,
      STEP_EIGHTH = 2'b10,
      STEP_SIXTEENTH = 2'b11
   } microstep_resolution_e;

   typedef struct packed {
      logic [3:0] absoluteMotionThreshold;
      logic [3:0] runCode;
      logic [3:0] holdCode;
      logic [3:0] vmaxCode;
      logic [3:0] vminCode;
      logic [8:0] safePosition;
      logic shaft;
      logic [3:0] accCode;
      logic linkSafe;
      logic sleepAllow;
      logic [3:0] relativeMotionThreshold;
      microstep_resolution_e microstepResolution;
   } motion_settings_s;
endpackage

// ### rtl/undervoltage_and_fuse_config.sv
// undervoltage supervisor, fuse store and parameter decode
// assumes one-cycle command strobes on core_clk, debounced comparators, rstn as por
`timescale 1ns/1ps
`default_nettype none

module undervoltage_and_fuse_config #(
   parameter longint UV_WINDOW_CYCLES = uv_fuse_pkg::UV_WINDOW_CYCLES,
   parameter int HOLD_REDUCE_CYCLES = uv_fuse_pkg::HOLD_REDUCE_CYCLES,
   parameter logic [7:0] FACTORY_TRIM0 = 8'h00,
   parameter logic [7:0] FACTORY_TRIM1 = 8'h00
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic batteryBelowLatchLevel,
   input wire logic batteryAboveRecoveryLevel,
   input wire logic pumpFaultFlag,
   input wire logic readStateCmd,
   input wire logic readAllStateCmd,
   input wire logic setTargetCmd,
   input wire logic [15:0] newTarget,
   input wire logic twoTargetMoveCmd,
   input wire logic [15:0] currentPosition,
   input wire logic motorStopped,
   input wire logic continuousSpeedMode,
   input wire logic linkLost,
   input wire logic errorCounterOverflow,
   input wire logic [2:0] addressPinBits,
   input wire logic loadMotionSettingsCmd,
   input wire uv_fuse_pkg::motion_settings_s motionSettingsIn,
   input wire logic fuseProgramCmd,
   input wire logic fuseReadbackCmd,
   input wire logic [2:0] fuseAddr,
   input wire logic [7:0] fuseWriteData,
   output uv_fuse_pkg::uv_state_e uvState,
   output logic motionHalted,
   output logic coilsHighZ,
   output logic resumeMotion,
   output logic undervoltageLatchFlag,
   output logic lostStepsFlag,
   output logic [15:0] targetPosition,
   output logic twoTargetAccepted,
   output logic twoTargetRefused,
   output logic [7:0] fuseReadData,
   output logic fuseReadValid,
   output logic fuseProgramDone,
   output logic fuseProgramRejected,
   output logic [6:0] nodeAddress,
   output uv_fuse_pkg::motion_settings_s activeSettings,
   output logic [10:0] safePositionRam,
   output logic gotoSafePlace,
   output logic absThresholdEnable,
   output logic [9:0] absThreshold10mV,
   output logic relThresholdEnable,
   output logic [9:0] relThreshold10mV,
   output logic [9:0] coilCurrentMa,
   output logic pwmOff,
   output logic bottomGrounded,
   output logic [4:0] microstepsPerFullStep,
   output logic rotateClockwise
);
   // ==========================================================================
   // reset release
   logic [1:0] rstSync_q;
   logic rstnInt;

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         rstSync_q <= 2'b00;
      else
         rstSync_q <= {rstSync_q[0], 1'b1};
   end
   assign rstnInt = rstSync_q[1];

   // ==========================================================================
   // undervoltage supervisor
   logic fault;
   logic statusRead;
   logic windowExpired;
   logic [31:0] uvTimer_q;
   uv_fuse_pkg::uv_state_e uvState_q;
   uv_fuse_pkg::uv_state_e uvState_d;

   assign fault = batteryBelowLatchLevel | pumpFaultFlag;
   assign statusRead = readStateCmd | readAllStateCmd;
   assign windowExpired = uvTimer_q >= 32'(UV_WINDOW_CYCLES);

   always_comb
   begin
      uvState_d = uvState_q;
      case (uvState_q)
         uv_fuse_pkg::UV_NORMAL:
            if (fault)
               uvState_d = uv_fuse_pkg::UV_HARD;
         uv_fuse_pkg::UV_HARD:
            uvState_d = uv_fuse_pkg::UV_HALT;
         uv_fuse_pkg::UV_HALT:
            if (windowExpired)
               uvState_d = uv_fuse_pkg::UV_SHUTDOWN;
            else if (batteryAboveRecoveryLevel && !pumpFaultFlag)
               uvState_d = uv_fuse_pkg::UV_NORMAL;
         uv_fuse_pkg::UV_SHUTDOWN:
            if (batteryAboveRecoveryLevel && !pumpFaultFlag && statusRead)
               uvState_d = uv_fuse_pkg::UV_NORMAL;
         default:
            uvState_d = uv_fuse_pkg::UV_NORMAL;
      endcase
   end

   // ram state: por clears it, nothing else stops it
   always_ff @(posedge core_clk or negedge rstnInt)
   begin
      if (!rstnInt)
         uvState_q <= uv_fuse_pkg::UV_NORMAL;
      else
         uvState_q <= uvState_d;
   end

   // window timer: hard entry through halt
   always_ff @(posedge core_clk or negedge rstnInt)
   begin
      if (!rstnInt)
         uvTimer_q <= 32'h0;
      else if (uvState_q == uv_fuse_pkg::UV_HARD || uvState_q == uv_fuse_pkg::UV_HALT)
      begin
         if (!windowExpired)
            uvTimer_q <= uvTimer_q + 32'h1;
      end
      else
         uvTimer_q <= 32'h0;
   end

   always_ff @(posedge core_clk or negedge rstnInt)
   begin
      if (!rstnInt)
      begin
         motionHalted <= 1'b0;
         coilsHighZ <= 1'b0;
         resumeMotion <= 1'b0;
      end
      else
      begin
         motionHalted <= uvState_d != uv_fuse_pkg::UV_NORMAL;
         coilsHighZ <= uvState_d != uv_fuse_pkg::UV_NORMAL;
         resumeMotion <= uvState_q == uv_fuse_pkg::UV_HALT
            && uvState_d == uv_fuse_pkg::UV_NORMAL;
      end
   end
   assign uvState = uvState_q;

   // set wins over clear when a fault lands with the status read
   always_ff @(posedge core_clk or negedge rstnInt)
   begin
      if (!rstnInt)
      begin
         undervoltageLatchFlag <= 1'b0;
         lostStepsFlag <= 1'b0;
      end
      else if (uvState_q == uv_fuse_pkg::UV_NORMAL && fault)
      begin
         undervoltageLatchFlag <= 1'b1;
         lostStepsFlag <= 1'b1;
      end
      else if (batteryAboveRecoveryLevel && statusRead && !fault)
      begin
         undervoltageLatchFlag <= 1'b0;
         lostStepsFlag <= 1'b0;
      end
   end

   // frozen while halted; shutdown copies the position
   always_ff @(posedge core_clk or negedge rstnInt)
   begin
      if (!rstnInt)
         targetPosition <= 16'h0000;
      else if (uvState_q == uv_fuse_pkg::UV_HALT && uvState_d == uv_fuse_pkg::UV_SHUTDOWN)
         targetPosition <= currentPosition;
      else if (setTargetCmd && uvState_q == uv_fuse_pkg::UV_NORMAL)
         targetPosition <= newTarget;
   end

   always_ff @(posedge core_clk or negedge rstnInt)
   begin
      if (!rstnInt)
      begin
         twoTargetAccepted <= 1'b0;
         twoTargetRefused <= 1'b0;
      end
      else
      begin
         twoTargetAccepted <= twoTargetMoveCmd && !flagged;
         twoTargetRefused <= twoTargetMoveCmd && flagged;
      end
   end
   logic flagged;
   assign flagged = undervoltageLatchFlag || pumpFaultFlag || lostStepsFlag;

   // ==========================================================================
   // fuse store: nonvolatile, so no reset; blank fuses read zero
   logic [7:0] fuseMem_q [8] = '{0: FACTORY_TRIM0, 1: FACTORY_TRIM1,
      default: uv_fuse_pkg::FUSE_BLANK};
   logic factoryLocked;
   logic userLocked;
   logic zapBlocked;

   assign factoryLocked = fuseMem_q[uv_fuse_pkg::ADDR_REL_LOCK][uv_fuse_pkg::FACTORY_LOCK_BIT];
   assign userLocked = fuseMem_q[uv_fuse_pkg::ADDR_REL_LOCK][uv_fuse_pkg::USER_LOCK_BIT];
   assign zapBlocked = userLocked
      || (factoryLocked && fuseAddr <= uv_fuse_pkg::FACTORY_LAST_ADDR);

   // or-ing only sets blank bits; ones are never zapped again
   always_ff @(posedge core_clk)
   begin
      if (fuseProgramCmd && !zapBlocked)
         fuseMem_q[fuseAddr] <= fuseMem_q[fuseAddr] | fuseWriteData;
   end

   always_ff @(posedge core_clk or negedge rstnInt)
   begin
      if (!rstnInt)
      begin
         fuseProgramDone <= 1'b0;
         fuseProgramRejected <= 1'b0;
         fuseReadValid <= 1'b0;
         fuseReadData <= 8'h00;
      end
      else
      begin
         fuseProgramDone <= fuseProgramCmd && !zapBlocked;
         fuseProgramRejected <= fuseProgramCmd && zapBlocked;
         fuseReadValid <= fuseReadbackCmd;
         if (fuseReadbackCmd)
            fuseReadData <= fuseMem_q[fuseAddr];
      end
   end

   // ==========================================================================
   // parameter load: fuses sampled once per reset, so zaps wait for a power cycle
   logic loadPending_q;

   always_ff @(posedge core_clk or negedge rstnInt)
   begin
      if (!rstnInt)
         loadPending_q <= 1'b1;
      else
         loadPending_q <= 1'b0;
   end

   always_ff @(posedge core_clk or negedge rstnInt)
   begin
      if (!rstnInt)
      begin
         activeSettings <= '0;
         nodeAddress <= 7'h00;
      end
      else if (loadPending_q)
      begin
         activeSettings.absoluteMotionThreshold <=
            fuseMem_q[uv_fuse_pkg::ADDR_THR_NODE][uv_fuse_pkg::HI_NIB +: 4];
         activeSettings.runCode <= fuseMem_q[uv_fuse_pkg::ADDR_CURRENT][uv_fuse_pkg::HI_NIB +: 4];
         activeSettings.holdCode <= fuseMem_q[uv_fuse_pkg::ADDR_CURRENT][uv_fuse_pkg::LO_NIB +: 4];
         activeSettings.vmaxCode <= fuseMem_q[uv_fuse_pkg::ADDR_SPEED][uv_fuse_pkg::HI_NIB +: 4];
         activeSettings.vminCode <= fuseMem_q[uv_fuse_pkg::ADDR_SPEED][uv_fuse_pkg::LO_NIB +: 4];
         activeSettings.safePosition <= {
            fuseMem_q[uv_fuse_pkg::ADDR_SAFE_HI][uv_fuse_pkg::SAFE_HI_LSB +: 3],
            fuseMem_q[uv_fuse_pkg::ADDR_SAFE_LO][uv_fuse_pkg::SAFE_LO_LSB +: 6]};
         activeSettings.shaft <= fuseMem_q[uv_fuse_pkg::ADDR_SAFE_HI][uv_fuse_pkg::SHAFT_BIT];
         activeSettings.accCode <= fuseMem_q[uv_fuse_pkg::ADDR_SAFE_HI][uv_fuse_pkg::LO_NIB +: 4];
         activeSettings.linkSafe <= fuseMem_q[uv_fuse_pkg::ADDR_SAFE_LO][uv_fuse_pkg::LINKSAFE_BIT];
         activeSettings.sleepAllow <= fuseMem_q[uv_fuse_pkg::ADDR_SAFE_LO][uv_fuse_pkg::SLEEP_BIT];
         activeSettings.relativeMotionThreshold <=
            fuseMem_q[uv_fuse_pkg::ADDR_REL_LOCK][uv_fuse_pkg::HI_NIB +: 4];
         activeSettings.microstepResolution <= uv_fuse_pkg::microstep_resolution_e'(
            fuseMem_q[uv_fuse_pkg::ADDR_REL_LOCK][uv_fuse_pkg::STEP_LSB +: 2]);
         nodeAddress <= {fuseMem_q[uv_fuse_pkg::ADDR_THR_NODE][uv_fuse_pkg::LO_NIB +: 4],
            addressPinBits};
      end
      else if (loadMotionSettingsCmd)
         activeSettings <= motionSettingsIn;
   end

   // ==========================================================================
   // decode of the active settings
   logic safeKeep;

   assign safeKeep = activeSettings.safePosition == uv_fuse_pkg::SAFE_KEEP_CODE;

   always_ff @(posedge core_clk or negedge rstnInt)
   begin
      if (!rstnInt)
      begin
         safePositionRam <= 11'h000;
         gotoSafePlace <= 1'b0;
         absThresholdEnable <= 1'b0;
         absThreshold10mV <= 10'h000;
         relThresholdEnable <= 1'b0;
         relThreshold10mV <= 10'h000;
         microstepsPerFullStep <= 5'h02;
      end
      else
      begin
         safePositionRam <= {activeSettings.safePosition, 2'b00};
         // keep pattern means stay put, so no safe move is requested
         gotoSafePlace <= (linkLost || errorCounterOverflow) && !safeKeep;
         absThresholdEnable <= activeSettings.absoluteMotionThreshold != 4'h0;
         absThreshold10mV <= 10'(activeSettings.absoluteMotionThreshold
            * uv_fuse_pkg::ABS_STEP_10MV);
         relThresholdEnable <= activeSettings.relativeMotionThreshold != 4'h0;
         relThreshold10mV <= 10'(activeSettings.relativeMotionThreshold
            * uv_fuse_pkg::REL_STEP_10MV);
         case (activeSettings.microstepResolution)
            uv_fuse_pkg::STEP_HALF: microstepsPerFullStep <= 5'h02;
            uv_fuse_pkg::STEP_QUARTER: microstepsPerFullStep <= 5'h04;
            uv_fuse_pkg::STEP_EIGHTH: microstepsPerFullStep <= 5'h08;
            default: microstepsPerFullStep <= 5'h10;
         endcase
      end
   end

   // direction is latched only outside continuous speed mode
   always_ff @(posedge core_clk or negedge rstnInt)
   begin
      if (!rstnInt)
         rotateClockwise <= 1'b0;
      else if (!continuousSpeedMode)
         rotateClockwise <= activeSettings.shaft;
   end

   // ==========================================================================
   // coil current: hold-off code passes 59 mA first so the coil does not snap to zero
   logic [31:0] holdTimer_q;
   logic holdSettled;

   assign holdSettled = holdTimer_q >= 32'(HOLD_REDUCE_CYCLES);

   always_ff @(posedge core_clk or negedge rstnInt)
   begin
      if (!rstnInt)
         holdTimer_q <= 32'h0;
      else if (!motorStopped || activeSettings.holdCode != uv_fuse_pkg::HOLD_OFF_CODE)
         holdTimer_q <= 32'h0;
      else if (!holdSettled)
         holdTimer_q <= holdTimer_q + 32'h1;
   end

   always_ff @(posedge core_clk or negedge rstnInt)
   begin
      if (!rstnInt)
      begin
         coilCurrentMa <= uv_fuse_pkg::ZERO_MA;
         pwmOff <= 1'b0;
         bottomGrounded <= 1'b0;
      end
      else
      begin
         pwmOff <= 1'b0;
         bottomGrounded <= 1'b0;
         if (!motorStopped)
            coilCurrentMa <= uv_fuse_pkg::CURRENT_MA[activeSettings.runCode];
         else if (activeSettings.holdCode != uv_fuse_pkg::HOLD_OFF_CODE)
            coilCurrentMa <= uv_fuse_pkg::CURRENT_MA[activeSettings.holdCode];
         else if (!holdSettled)
            coilCurrentMa <= uv_fuse_pkg::CURRENT_MA[0];
         else
         begin
            coilCurrentMa <= uv_fuse_pkg::ZERO_MA;
            pwmOff <= 1'b1;
            bottomGrounded <= 1'b1;
         end
      end
   end
endmodule

`default_nettype wire
